// ### verilog/acadd_pkg.sv
// Purpose: constants for the accumulator add unit
// Assumes: 8-bit datapath, one core clock
// Notes: opcode bytes and form selectors for the unit, bit positions for its adder
package acadd_pkg;
    localparam int ACADD_W = 8;
    localparam logic [7:0] ACADD_OP_ADD_DIR = 8'h25;
    localparam logic [7:0] ACADD_OP_ADD_IMM = 8'h24;
    localparam logic [7:0] ACADD_OP_CADD_DIR = 8'h35;
    localparam logic [7:0] ACADD_OP_CADD_IMM = 8'h34;
    localparam logic [4:0] ACADD_OP_ADD_REG_HI = 5'h05;
    localparam logic [4:0] ACADD_OP_CADD_REG_HI = 5'h07;
    localparam logic [6:0] ACADD_OP_ADD_IND_HI = 7'h13;
    localparam logic [6:0] ACADD_OP_CADD_IND_HI = 7'h1b;
    localparam logic [7:0] ACADD_ACC_RST = 8'h00;
    localparam logic ACADD_FLAG_RST = 1'b0;
    localparam int ACADD_AUX_BIT = 4;
    localparam int ACADD_B6_BIT = 7;
    localparam int ACADD_RSEL_W = 3;
    localparam int ACADD_REG_HI_LSB = 3;
    localparam int ACADD_IND_HI_LSB = 1;
    localparam int ACADD_PSEL_BIT = 0;
    localparam logic [2:0] ACADD_RSEL_RST = 3'h0;
    localparam logic ACADD_BIT_RST = 1'b0;
    typedef enum logic [1:0] {
        ACADD_SRC_REG = 2'b00,
        ACADD_SRC_DIR = 2'b01,
        ACADD_SRC_IND = 2'b10,
        ACADD_SRC_IMM = 2'b11
    } acadd_src_t;
    typedef enum logic [1:0] {
        ACADD_IDLE = 2'b00,
        ACADD_WAIT_OPND = 2'b01
    } acadd_state_t;
endpackage

// ### verilog/acadd_adder.sv
// Purpose: 8-bit adder with carry-in producing carry, aux-carry, overflow
// Assumes: purely combinational
// Notes: flags taken from partial sums
`timescale 1ns/1ps
module acadd_adder
    import acadd_pkg::*;
(
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] sum,
    output logic carry,
    output logic aux_carry,
    output logic overflow
);
    logic [ACADD_AUX_BIT:0] low_sum;
    logic [ACADD_B6_BIT:0] low7_sum;
    logic [ACADD_W:0] full_sum;
    always_comb begin
        low_sum = {1'b0, a[ACADD_AUX_BIT-1:0]} + {1'b0, b[ACADD_AUX_BIT-1:0]}
                  + {{ACADD_AUX_BIT{1'b0}}, cin};
        low7_sum = {1'b0, a[ACADD_B6_BIT-1:0]} + {1'b0, b[ACADD_B6_BIT-1:0]}
                   + {{ACADD_B6_BIT{1'b0}}, cin};
        full_sum = {1'b0, a} + {1'b0, b} + {{ACADD_W{1'b0}}, cin};
        sum = full_sum[ACADD_W-1:0];
        carry = full_sum[ACADD_W];
        aux_carry = low_sum[ACADD_AUX_BIT];
        overflow = low7_sum[ACADD_B6_BIT] ^ full_sum[ACADD_W];
    end
endmodule

// ### verilog/acadd_unit.sv
// Purpose: executes add and add-with-carry into the accumulator
// Assumes: sequencer presents opcode then operand byte; inputs synchronous
// Notes: acc and flags are held here and exported from flip-flops
// Notes: refused opcodes leave acc and flags untouched
// Notes on behaviour
// - add source byte into accumulator
// - carry from bit7, aux from bit3
// - overflow when bit6/bit7 carries differ
// - four source forms accepted
// - direct add, two bytes, two cycles
// - immediate add, two bytes
// - add-with-carry includes carry flag
// - c3 plus aa gives 6d, carry, overflow
// - direct add-with-carry, two bytes
// - immediate add-with-carry, two bytes
`timescale 1ns/1ps
module acadd_unit
    import acadd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic opnd_valid,
    input wire logic [7:0] opnd_byte,
    input wire logic [7:0] src_data,
    output logic op_ack,
    output logic need_operand,
    output logic [2:0] working_register_sel,
    output logic pointer_register_sel,
    output logic [1:0] src_form,
    output logic [7:0] acc,
    output logic carry_flag,
    output logic aux_carry_flag,
    output logic overflow_flag,
    output logic done
);
    acadd_state_t state_reg;
    logic add_with_carry_op_reg;
    acadd_src_t form_reg;
    logic [2:0] rsel_reg;
    logic isel_reg;
    logic is_add;
    logic is_carry_op;
    logic is_two_byte;
    acadd_src_t form_dec;
    logic exec;
    logic [7:0] operand;
    logic [7:0] sum;
    logic c_out;
    logic aux_out;
    logic ovf_out;
    logic cin;

    always_comb begin
        is_add = 1'b1;
        is_carry_op = 1'b0;
        is_two_byte = 1'b0;
        form_dec = ACADD_SRC_REG;
        if (op_byte == ACADD_OP_ADD_DIR) begin
            is_two_byte = 1'b1;
            form_dec = ACADD_SRC_DIR;
        end else if (op_byte == ACADD_OP_ADD_IMM) begin
            is_two_byte = 1'b1;
            form_dec = ACADD_SRC_IMM;
        end else if (op_byte == ACADD_OP_CADD_DIR) begin
            is_carry_op = 1'b1;
            is_two_byte = 1'b1;
            form_dec = ACADD_SRC_DIR;
        end else if (op_byte == ACADD_OP_CADD_IMM) begin
            is_carry_op = 1'b1;
            is_two_byte = 1'b1;
            form_dec = ACADD_SRC_IMM;
        end else if (op_byte[ACADD_W-1:ACADD_REG_HI_LSB] == ACADD_OP_ADD_REG_HI) begin
            form_dec = ACADD_SRC_REG;
        end else if (op_byte[ACADD_W-1:ACADD_REG_HI_LSB] == ACADD_OP_CADD_REG_HI) begin
            is_carry_op = 1'b1;
            form_dec = ACADD_SRC_REG;
        end else if (op_byte[ACADD_W-1:ACADD_IND_HI_LSB] == ACADD_OP_ADD_IND_HI) begin
            form_dec = ACADD_SRC_IND;
        end else if (op_byte[ACADD_W-1:ACADD_IND_HI_LSB] == ACADD_OP_CADD_IND_HI) begin
            is_carry_op = 1'b1;
            form_dec = ACADD_SRC_IND;
        end else begin
            // anything else belongs to another unit
            is_add = 1'b0;
        end
    end

    // refusal lets the sequencer route other opcodes elsewhere
    assign op_ack = (state_reg == ACADD_IDLE) && op_valid && is_add;

    // a second byte is only looked at after a two-byte opcode
    // operand-wait sequence for two-byte forms
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ACADD_IDLE;
        end else begin
            unique case (state_reg)
                ACADD_IDLE: begin
                    if (op_ack && is_two_byte) begin
                        state_reg <= ACADD_WAIT_OPND;
                    end
                end
                ACADD_WAIT_OPND: begin
                    if (opnd_valid) begin
                        state_reg <= ACADD_IDLE;
                    end
                end
                default: begin
                    state_reg <= ACADD_IDLE;
                end
            endcase
        end
    end

    // opcode fields kept for the operand cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            add_with_carry_op_reg <= ACADD_BIT_RST;
            form_reg <= ACADD_SRC_REG;
            rsel_reg <= ACADD_RSEL_RST;
            isel_reg <= ACADD_BIT_RST;
        end else if (op_ack) begin
            add_with_carry_op_reg <= is_carry_op;
            form_reg <= form_dec;
            rsel_reg <= op_byte[ACADD_RSEL_W-1:0];
            isel_reg <= op_byte[ACADD_PSEL_BIT];
        end
    end

    assign need_operand = (state_reg == ACADD_WAIT_OPND);

    // selects follow the opcode at once so the fetch fits the same cycle
    always_comb begin
        if (state_reg == ACADD_WAIT_OPND) begin
            src_form = form_reg;
            working_register_sel = rsel_reg;
            pointer_register_sel = isel_reg;
        end else begin
            src_form = form_dec;
            working_register_sel = op_byte[ACADD_RSEL_W-1:0];
            pointer_register_sel = op_byte[ACADD_PSEL_BIT];
        end
    end

    // one-byte forms execute on the opcode; two-byte on the operand byte
    always_comb begin
        exec = 1'b0;
        if (state_reg == ACADD_IDLE) begin
            exec = op_ack && !is_two_byte;
        end else begin
            exec = opnd_valid;
        end
    end

    always_comb begin
        operand = src_data;
        if (need_operand && form_reg == ACADD_SRC_IMM) begin
            operand = opnd_byte;
        end
    end

    // for add-with-carry the stored carry feeds in, so chained adds see the last carry-out
    // carry joins the sum
    assign cin = (need_operand ? add_with_carry_op_reg : is_carry_op) & carry_flag;

    // one shared adder serves every add form
    acadd_adder u_adder (
        .a(acc),
        .b(operand),
        .cin(cin),
        .sum(sum),
        .carry(c_out),
        .aux_carry(aux_out),
        .overflow(ovf_out)
    );

    // a refused opcode never raises exec, so acc holds
    // write back result
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= ACADD_ACC_RST;
        end else if (exec) begin
            acc <= sum;
        end
    end

    // flags change only together with the accumulator
    // flags follow adder
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            carry_flag <= ACADD_FLAG_RST;
            aux_carry_flag <= ACADD_FLAG_RST;
            overflow_flag <= ACADD_FLAG_RST;
        end else if (exec) begin
            carry_flag <= c_out;
            aux_carry_flag <= aux_out;
            overflow_flag <= ovf_out;
        end
    end

    // done is exec registered: it rises on the execute edge, together with acc
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= ACADD_BIT_RST;
        end else begin
            done <= exec;
        end
    end
endmodule

// ### tb/acadd_asserts.sv
// Purpose: port checks for acadd_unit
// Assumes: one clock, async low reset
// Notes: flags rebuilt from the sum
`timescale 1ns/1ps
module acadd_asserts
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic op_valid,
    input wire logic [7:0] op_byte,
    input wire logic opnd_valid,
    input wire logic [7:0] opnd_byte,
    input wire logic [7:0] src_data,
    input wire logic op_ack,
    input wire logic need_operand,
    input wire logic [2:0] working_register_sel,
    input wire logic pointer_register_sel,
    input wire logic [7:0] acc,
    input wire logic carry_flag,
    input wire logic aux_carry_flag,
    input wire logic overflow_flag,
    input wire logic done
);
    logic [7:0] op_reg, v, s;
    logic c, aux, ovf, ci, ex, tk, two, ad;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b) op_reg <= 8'h00;
        else if (tk) op_reg <= op_byte;
    assign ad = op_byte[7:5] == 3'h1 && (op_byte[3] || op_byte[2]);
    assign tk = op_valid && op_ack;
    assign two = ad && op_byte[3:1] == 3'h2;
    assign ex = (tk && !two) || (need_operand && opnd_valid);
    // carry in only for add-with-carry, bit 4 of the opcode
    assign ci = (need_operand ? op_reg[4] : op_byte[4]) && carry_flag;
    assign v = need_operand && !op_reg[0] ? opnd_byte : src_data;
    assign {c, s} = {1'b0, acc} + {1'b0, v} + {8'h00, ci};
    assign aux = s[4] ^ acc[4] ^ v[4];
    assign ovf = c ^ s[7] ^ acc[7] ^ v[7];
    a_two_wait: assert property (tk && two |=> need_operand) else $error("wait");
    a_done_pulse: assert property (ex |=> done) else $error("done");
    a_idle_hold: assert property (!ex |=> !done && $stable(acc)) else $error("hold");
    a_ack_form: assert property (op_valid && !need_operand |-> op_ack == ad) else $error("ack");
    a_acc_sum: assert property (ex |=> acc == $past(s)) else $error("sum");
    a_carry_out: assert property (ex |=> carry_flag == $past(c)) else $error("carry");
    a_aux_carry: assert property (ex |=> aux_carry_flag == $past(aux)) else $error("aux");
    a_ovf_flag: assert property (ex |=> overflow_flag == $past(ovf)) else $error("ovf");
    a_sel_field: assert property (op_valid && !need_operand |->
        working_register_sel == op_byte[2:0] && pointer_register_sel == op_byte[0])
        else $error("sel");
endmodule
bind acadd_unit acadd_asserts i_chk (.*);

// ### tb/acadd_src_model.sv
// Purpose: operand source of the sequencer
// Assumes: register n holds a8+n, ram byte a holds a^3c
// Notes: immediate form gets a wrong byte
`timescale 1ns/1ps
module acadd_src_model
    import acadd_pkg::*;
(
    input wire logic [1:0] src_form,
    input wire logic [2:0] working_register_sel,
    input wire logic pointer_register_sel,
    input wire logic [7:0] opnd_byte,
    output logic [7:0] src_data
);
    assign src_data = src_form == ACADD_SRC_REG ? {5'h15, working_register_sel}
        : src_form == ACADD_SRC_IND ? {7'h54, pointer_register_sel} ^ 8'h3c
        : src_form == ACADD_SRC_DIR ? opnd_byte ^ 8'h3c : ~opnd_byte;
endmodule

// ### tb/tb.sv
// Purpose: bench for acadd_unit
// Assumes: inputs change on the falling edge
// Notes: row holds opcode, byte two, acc, flags
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0, rst_b = 1'b0, op_valid = 1'b0, opnd_valid = 1'b0;
    logic [7:0] op_byte = 8'h00, opnd_byte = 8'h00, src_data, acc, flg;
    logic [2:0] working_register_sel;
    logic [1:0] src_form;
    logic pointer_register_sel, op_ack, need_operand, carry_flag, aux_carry_flag;
    logic overflow_flag, done;
    int miscompares = 0, n_compared = 0;
    logic [31:0] rows [8] = '{32'h24c3c300, 32'h2a006d05, 32'h34016f00, 32'h3a001906,
        32'h2580d502, 32'h35f0a106, 32'h26003505, 32'h3700cb00};
    assign flg = {5'h0, carry_flag, aux_carry_flag, overflow_flag};
    acadd_unit i_dut (.*);
    acadd_src_model i_src (.*);
    task chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    task test_done;
        $display("miscompares %0d of %0d", miscompares, n_compared);
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task run(input logic [31:0] r);
        @(negedge clk);
        op_valid = 1'b1;
        op_byte = r[31:24];
        // opcode stays up in the wait cycle, where it is ignored
        if (r[31:29] == 3'h1 && r[27:25] == 3'h2) begin
            @(negedge clk);
            opnd_valid = 1'b1;
            opnd_byte = r[23:16];
        end
        @(negedge clk);
        op_valid = 1'b0;
        opnd_valid = 1'b0;
        chk(acc, r[15:8]);
        chk(flg, r[7:0]);
        chk({7'h0, done}, {7'h0, r[31:29] == 3'h1 && |r[27:26]});
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        repeat (300) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        foreach (rows[i]) run(rows[i]);
        run(32'h0400cb00);
        rst_b = 1'b0;
        #1 chk(acc | flg, 8'h00);
        @(negedge clk);
        rst_b = 1'b1;
        run(32'h2d00ad00);
        test_done();
    end
endmodule
